/* File: oat_map.vh */
// Register map and field layout of the timing engine control block
// Included by every design file of the block; definitions only
`ifndef OAT_MAP_VH
`define OAT_MAP_VH
`define OAT_ADDR_W          8
`define OAT_DATA_W          24
`define OAT_CNT_W           16
`define OAT_AVG_W           4
`define OAT_REG_RST2_BEGIN  8'h19
`define OAT_REG_RST2_FINISH 8'h1A
`define OAT_REG_RST3_BEGIN  8'h1B
`define OAT_REG_RST3_FINISH 8'h1C
`define OAT_REG_PERIOD      8'h1D
`define OAT_REG_ENABLE_AVG  8'h1E
`define OAT_CNT_MSB         15
`define OAT_ENABLE_BIT      8
`define OAT_AVG_MSB         3
`define OAT_CNT_RESET       16'h0000
`define OAT_AVG_RESET       4'h0
`define OAT_AVG_LAST        4'hF
`define OAT_ZERO_DATA       24'h000000
`define OAT_CNT_ONE         16'h0001
`define OAT_AVG_ONE         4'h1
`endif

/* File: oat_phase_window.v */
// Phase window: one reset-phase output from begin and finish compares
// Assumes the period counter and enable come from the timing engine
`timescale 1ns/1ns
`include "oat_map.vh"
module oat_phase_window (
	input  wire                  clk_in,
	input  wire                  rst_in,
	input  wire                  enable_in,
	input  wire [`OAT_CNT_MSB:0] count_in,
	input  wire [`OAT_CNT_MSB:0] begin_in,
	input  wire [`OAT_CNT_MSB:0] finish_in,
	output reg                   phase_out
);
	// Inclusive window; begin above finish gives no pulse rather than wrap
	always @(posedge clk_in) begin
		if (rst_in || !enable_in)
			phase_out <= 1'b0;
		else
			phase_out <= (count_in >= begin_in) && (count_in <= finish_in);
	end
endmodule // oat_phase_window

/* File: oat_averager.v */
// Sample averager: accumulates count+1 ADC samples and emits their mean
// Assumes one sample per valid pulse from the converter
`timescale 1ns/1ns
`include "oat_map.vh"
module oat_averager (
	input  wire                  clk_in,
	input  wire                  rst_in,
	input  wire [`OAT_AVG_MSB:0] avg_count_in,
	input  wire                  sample_valid_in,
	input  wire [`OAT_DATA_W-1:0] sample_in,
	output reg                   result_valid_out,
	output reg  [`OAT_DATA_W-1:0] result_out
);
	reg [`OAT_DATA_W+3:0] acc;
	reg [`OAT_AVG_MSB:0]  taken;
	wire [`OAT_DATA_W+3:0] sum = acc + {4'h0, sample_in};
	// Divide by count+1; a general divider is traded for area simplicity
	wire [`OAT_DATA_W+3:0] mean = sum / ({24'h000000, avg_count_in} + 28'h0000001);
	always @(posedge clk_in) begin
		if (rst_in) begin
			acc              <= 28'h0000000;
			taken            <= `OAT_AVG_RESET;
			result_valid_out <= 1'b0;
			result_out       <= `OAT_ZERO_DATA;
		end else begin
			result_valid_out <= 1'b0;
			if (sample_valid_in) begin
				if (taken >= avg_count_in) begin
					result_out       <= mean[`OAT_DATA_W-1:0];
					result_valid_out <= 1'b1;
					acc              <= 28'h0000000;
					taken            <= `OAT_AVG_RESET;
				end else begin
					acc   <= sum;
					taken <= taken + `OAT_AVG_ONE;
				end
			end
		end
	end
endmodule // oat_averager

/* File: oat_timing_ctrl.v */
// Timing engine control: registers, period counter, ADC reset phases 2/3
// Assumes a synchronous register port (address, write strobe, read strobe)
// Function
// - Phase 2 begin count register, 16 bits
// - Phase 2 finish count register, 16 bits
// - Phase 3 begin count register, 16 bits
// - Phase 3 finish count register, 16 bits
// - Period count register sets counter terminal
// - Counter runs to period, then wraps zero
// - Enable bit 8, resets off
// - Enabled engine drives phases from compares
// - Average count is field plus one
// - Zero means single conversion, 15 means 16
// - Converter outputs average of several conversions
`timescale 1ns/1ns
`include "oat_map.vh"
module oat_timing_ctrl (
	input  wire                    CORE_CLK_IN,
	input  wire                    RST_IN,
	input  wire [`OAT_ADDR_W-1:0]  REG_ADDR_IN,
	input  wire                    REG_WRITE_IN,
	input  wire [`OAT_DATA_W-1:0]  REG_WDATA_IN,
	input  wire                    REG_READ_IN,
	output reg  [`OAT_DATA_W-1:0]  REG_RDATA_OUT,
	output reg                     REG_RVALID_OUT,
	input  wire                    SAMPLE_VALID_IN,
	input  wire [`OAT_DATA_W-1:0]  SAMPLE_IN,
	output wire                    RESULT_VALID_OUT,
	output wire [`OAT_DATA_W-1:0]  RESULT_OUT,
	output reg  [`OAT_CNT_MSB:0]   PERIOD_COUNT_OUT,
	output reg                     PERIOD_WRAP_OUT,
	output wire                    ADC_RESET2_OUT,
	output wire                    ADC_RESET3_OUT
);
	reg [`OAT_CNT_MSB:0] adc_reset2_begin_count;
	reg [`OAT_CNT_MSB:0] adc_reset2_finish_count;
	reg [`OAT_CNT_MSB:0] adc_reset3_begin_count;
	reg [`OAT_CNT_MSB:0] adc_reset3_finish_count;
	reg [`OAT_CNT_MSB:0] pulse_period_count;
	reg                  timing_engine_enable;
	reg [`OAT_AVG_MSB:0] sample_average_count;
	reg [`OAT_DATA_W-1:0] next_rdata;

	// Only the documented fields are stored; reserved bits are dropped on write
	always @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			adc_reset2_begin_count  <= `OAT_CNT_RESET;
			adc_reset2_finish_count <= `OAT_CNT_RESET;
			adc_reset3_begin_count  <= `OAT_CNT_RESET;
			adc_reset3_finish_count <= `OAT_CNT_RESET;
			pulse_period_count      <= `OAT_CNT_RESET;
			timing_engine_enable    <= 1'b0;
			sample_average_count    <= `OAT_AVG_RESET;
		end else if (REG_WRITE_IN) begin
			case (REG_ADDR_IN)
				`OAT_REG_RST2_BEGIN:  adc_reset2_begin_count  <= REG_WDATA_IN[`OAT_CNT_MSB:0];
				`OAT_REG_RST2_FINISH: adc_reset2_finish_count <= REG_WDATA_IN[`OAT_CNT_MSB:0];
				`OAT_REG_RST3_BEGIN:  adc_reset3_begin_count  <= REG_WDATA_IN[`OAT_CNT_MSB:0];
				`OAT_REG_RST3_FINISH: adc_reset3_finish_count <= REG_WDATA_IN[`OAT_CNT_MSB:0];
				`OAT_REG_PERIOD:      pulse_period_count      <= REG_WDATA_IN[`OAT_CNT_MSB:0];
				`OAT_REG_ENABLE_AVG: begin
					timing_engine_enable <= REG_WDATA_IN[`OAT_ENABLE_BIT];
					sample_average_count <= REG_WDATA_IN[`OAT_AVG_MSB:0];
				end
				default: ;
			endcase
		end
	end

	always @* begin
		next_rdata = `OAT_ZERO_DATA;
		case (REG_ADDR_IN)
			`OAT_REG_RST2_BEGIN:  next_rdata[`OAT_CNT_MSB:0] = adc_reset2_begin_count;
			`OAT_REG_RST2_FINISH: next_rdata[`OAT_CNT_MSB:0] = adc_reset2_finish_count;
			`OAT_REG_RST3_BEGIN:  next_rdata[`OAT_CNT_MSB:0] = adc_reset3_begin_count;
			`OAT_REG_RST3_FINISH: next_rdata[`OAT_CNT_MSB:0] = adc_reset3_finish_count;
			`OAT_REG_PERIOD:      next_rdata[`OAT_CNT_MSB:0] = pulse_period_count;
			`OAT_REG_ENABLE_AVG: begin
				next_rdata[`OAT_ENABLE_BIT] = timing_engine_enable;
				next_rdata[`OAT_AVG_MSB:0]  = sample_average_count;
			end
			default: next_rdata = `OAT_ZERO_DATA;
		endcase
	end

	always @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			REG_RDATA_OUT  <= `OAT_ZERO_DATA;
			REG_RVALID_OUT <= 1'b0;
		end else begin
			REG_RVALID_OUT <= REG_READ_IN;
			if (REG_READ_IN)
				REG_RDATA_OUT <= next_rdata;
		end
	end

	// Counter holds at zero while disabled so a restart begins a clean period
	always @(posedge CORE_CLK_IN) begin
		if (RST_IN || !timing_engine_enable) begin
			PERIOD_COUNT_OUT <= `OAT_CNT_RESET;
			PERIOD_WRAP_OUT  <= 1'b0;
		end else if (PERIOD_COUNT_OUT >= pulse_period_count) begin
			PERIOD_COUNT_OUT <= `OAT_CNT_RESET;
			PERIOD_WRAP_OUT  <= 1'b1;
		end else begin
			PERIOD_COUNT_OUT <= PERIOD_COUNT_OUT + `OAT_CNT_ONE;
			PERIOD_WRAP_OUT  <= 1'b0;
		end
	end

	oat_phase_window u_phase2 (
		.clk_in    (CORE_CLK_IN),
		.rst_in    (RST_IN),
		.enable_in (timing_engine_enable),
		.count_in  (PERIOD_COUNT_OUT),
		.begin_in  (adc_reset2_begin_count),
		.finish_in (adc_reset2_finish_count),
		.phase_out (ADC_RESET2_OUT)
	);

	oat_phase_window u_phase3 (
		.clk_in    (CORE_CLK_IN),
		.rst_in    (RST_IN),
		.enable_in (timing_engine_enable),
		.count_in  (PERIOD_COUNT_OUT),
		.begin_in  (adc_reset3_begin_count),
		.finish_in (adc_reset3_finish_count),
		.phase_out (ADC_RESET3_OUT)
	);

	oat_averager u_avg (
		.clk_in           (CORE_CLK_IN),
		.rst_in           (RST_IN),
		.avg_count_in     (sample_average_count),
		.sample_valid_in  (SAMPLE_VALID_IN),
		.sample_in        (SAMPLE_IN),
		.result_valid_out (RESULT_VALID_OUT),
		.result_out       (RESULT_OUT)
	);
endmodule // oat_timing_ctrl

/* File: oat_timing_ctrl_monitor.sv */
// Checker of the timing engine control ports
// Bound to oat_timing_ctrl from the testbench top file
`timescale 1ns/1ns
module oat_monitor (
	input wire        CORE_CLK_IN,
	input wire        RST_IN,
	input wire [7:0]  REG_ADDR_IN,
	input wire        REG_READ_IN,
	input wire [23:0] REG_RDATA_OUT,
	input wire        REG_RVALID_OUT,
	input wire        SAMPLE_VALID_IN,
	input wire        RESULT_VALID_OUT,
	input wire [15:0] PERIOD_COUNT_OUT,
	input wire        PERIOD_WRAP_OUT,
	input wire        ADC_RESET2_OUT,
	input wire        ADC_RESET3_OUT
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);
	rd_answer_a: assert property (REG_READ_IN |=> REG_RVALID_OUT) else $error("no answer");
	upper_zero_a: assert property (REG_RVALID_OUT |-> REG_RDATA_OUT[23:16] == 8'h00)
		else $error("upper bits set");
	unmapped_zero_a: assert property (REG_RVALID_OUT && ($past(REG_ADDR_IN) < 8'h19
		|| $past(REG_ADDR_IN) > 8'h1E) |-> REG_RDATA_OUT == 24'h0) else $error("unmapped");
	rdata_hold_a: assert property ($changed(REG_RDATA_OUT) |-> REG_RVALID_OUT)
		else $error("rdata moved");
	count_step_a: assert property (PERIOD_COUNT_OUT != 16'h0 |->
		PERIOD_COUNT_OUT == $past(PERIOD_COUNT_OUT) + 16'h1) else $error("count step");
	wrap_zero_a: assert property (PERIOD_WRAP_OUT |-> PERIOD_COUNT_OUT == 16'h0)
		else $error("wrap");
	reset_quiet_a: assert property ($fell(RST_IN) |-> !ADC_RESET2_OUT && !ADC_RESET3_OUT
		&& PERIOD_COUNT_OUT == 16'h0 && !RESULT_VALID_OUT) else $error("reset state");
	result_cause_a: assert property (RESULT_VALID_OUT |-> $past(SAMPLE_VALID_IN))
		else $error("result cause");
	cover property (PERIOD_WRAP_OUT);
	cover property (ADC_RESET2_OUT && ADC_RESET3_OUT == 1'b0);
	cover property (RESULT_VALID_OUT);
endmodule // oat_monitor

/* File: tb_top.sv */
// Testbench of the timing engine control block
// Inputs change at the falling edge; checker bound at the foot
`timescale 1ns/1ns
module tb_top;
	reg         CORE_CLK_IN, RST_IN, REG_WRITE_IN, REG_READ_IN, SAMPLE_VALID_IN;
	reg  [7:0]  REG_ADDR_IN;
	reg  [23:0] REG_WDATA_IN, SAMPLE_IN, sum;
	wire [23:0] REG_RDATA_OUT, RESULT_OUT;
	wire        REG_RVALID_OUT, RESULT_VALID_OUT, PERIOD_WRAP_OUT, ADC_RESET2_OUT, ADC_RESET3_OUT;
	wire [15:0] PERIOD_COUNT_OUT;
	reg  [31:0] seed = 32'h83A8D2E7;
	reg  [3:0]  n;
	integer     n_mismatch = 0, tests_run = 0, i, k;
	oat_timing_ctrl i_dut (.*);
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	// Reserved bits read back as zero
	function [23:0] fmask(input [7:0] a);
		fmask = a == 8'h1E ? 24'h10F : (a > 8'h18 && a < 8'h1E) ? 24'hFFFF : 24'h0;
	endfunction
	task chk(input [23:0] seen, input [23:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [23:0] d);
		begin
			@(negedge CORE_CLK_IN) {REG_ADDR_IN, REG_WDATA_IN, REG_WRITE_IN} = {a, d, 1'b1};
			@(negedge CORE_CLK_IN) REG_WRITE_IN = 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [23:0] e);
		begin
			@(negedge CORE_CLK_IN) {REG_ADDR_IN, REG_READ_IN} = {a, 1'b1};
			@(negedge CORE_CLK_IN) REG_READ_IN = 1'b0;
			chk(REG_RVALID_OUT, 24'h1);
			chk(REG_RDATA_OUT, e);
		end
	endtask
	task stop_test;
		begin
			if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
			else $display("Run complete: FAIL");
			$finish;
		end
	endtask
	initial begin
		CORE_CLK_IN = 1'b0;
		forever #50 CORE_CLK_IN = ~CORE_CLK_IN;
	end
	// Whole run is under two hundred cycles
	initial begin
		#400000 n_mismatch = n_mismatch + 1;
		stop_test;
	end
	initial begin
		{RST_IN, REG_WRITE_IN, REG_READ_IN, SAMPLE_VALID_IN} = 4'b1000;
		{REG_ADDR_IN, REG_WDATA_IN, SAMPLE_IN} = 56'h0;
		repeat (5) @(negedge CORE_CLK_IN);
		RST_IN = 1'b0;
		for (i = 8'h18; i < 8'h20; i = i + 1) begin
			rd(i, 24'h0);
			seed = xs(seed);
			wr(i, seed[23:0] & fmask(i));
			rd(i, seed[23:0] & fmask(i));
		end
		wr(8'h19, 24'h2);
		wr(8'h1A, 24'h4);
		wr(8'h1B, 24'h5);
		wr(8'h1C, 24'h5);
		wr(8'h1D, 24'h6);
		wr(8'h1E, 24'h100);
		for (k = 0; PERIOD_WRAP_OUT !== 1'b1 && k < 20; k = k + 1) @(negedge CORE_CLK_IN);
		// Phases lag the count by one cycle
		for (i = 0; i < 14; i = i + 1) begin
			chk({PERIOD_WRAP_OUT, PERIOD_COUNT_OUT}, {i % 7 == 0, 16'h0} | i % 7);
			k = (i + 6) % 7;
			chk({ADC_RESET2_OUT, ADC_RESET3_OUT}, {k > 1 && k < 5, k == 5});
			@(negedge CORE_CLK_IN);
		end
		for (k = 0; k < 3; k = k + 1) begin
			n = k == 2 ? 4'hF : k * 2;
			wr(8'h1E, {20'h0, n});
			// The old enable still counts at the write edge; look one cycle later
			@(negedge CORE_CLK_IN);
			chk({PERIOD_COUNT_OUT, ADC_RESET2_OUT}, 24'h0);
			sum = 24'h0;
			for (i = 0; i <= n; i = i + 1) begin
				seed = xs(seed);
				sum = sum + seed[15:0];
				@(negedge CORE_CLK_IN) {SAMPLE_VALID_IN, SAMPLE_IN} = {9'h100, seed[15:0]};
			end
			@(negedge CORE_CLK_IN) SAMPLE_VALID_IN = 1'b0;
			for (i = 0; RESULT_VALID_OUT !== 1'b1 && i < 4; i = i + 1) @(negedge CORE_CLK_IN);
			chk(RESULT_VALID_OUT, 24'h1);
			chk(RESULT_OUT, sum / (n + 1));
		end
		wr(8'h1E, 24'h100);
		@(negedge CORE_CLK_IN) RST_IN = 1'b1;
		repeat (2) @(negedge CORE_CLK_IN);
		RST_IN = 1'b0;
		rd(8'h1E, 24'h0);
		chk({PERIOD_COUNT_OUT, ADC_RESET2_OUT, ADC_RESET3_OUT}, 24'h0);
		stop_test;
	end
endmodule // tb_top
bind oat_timing_ctrl oat_monitor i_mon (.*);
